//--- rtl/anr_ability_regs.sv
`timescale 1ns/1ps
module anr_ability_regs
  import anr_pkg::*;
#(
  parameter bit LOCAL_NP_ABLE = 1'b0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // management register port
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // negotiation engine
  input  wire logic        an_restart,
  input  wire anr_link_s   link,
  output anr_advert_s      advert,
  output anr_sel_e         partner_sel,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [15:0] local_advert_reg;
  logic [15:0] partner_ability_reg;
  logic [15:0] expansion_reg;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  wire wr_advert = wr && (addr == ADDR_LOCAL_ADVERT);
  wire wr_mask   = wr && (addr == ADDR_IRQ_MASK);
  wire rd_status = rd && (addr == ADDR_IRQ_STATUS);

  // only fault and tech bits take writes; np and selector are fixed
  wire [15:0] next_local_advert =
    (wdata & WRITE_MASK_ADVERT) | {11'h000, SEL_IEEE8023};

  wire [3:0] tech_field =
    local_advert_reg[TECH_MSB:TECH_LSB];

  wire [4:0] rx_sel = link.page[SEL_MSB:0];

  function automatic anr_sel_e decode_sel(input logic [4:0] s);
    case (s)
      SEL_IEEE8023:   decode_sel = ANR_SEL_ETHERNET;
      SEL_ISLAN:      decode_sel = ANR_SEL_ISLAN;
      SEL_TOKEN_RING: decode_sel = ANR_SEL_TOKEN;
      SEL_SERIAL_BUS: decode_sel = ANR_SEL_SERIAL;
      default:        decode_sel = ANR_SEL_RESERVED;
    endcase
  endfunction : decode_sel

  wire anr_sel_e next_partner_sel = decode_sel(rx_sel);

  // bit 2 partner np able, bit 1 local np able, bit 0 partner an able
  wire [15:0] next_expansion = {13'h0000, link.partner_np_able,
                                LOCAL_NP_ABLE, link.partner_an_able};

  wire [15:0] next_rdata =
    (addr == ADDR_LOCAL_ADVERT) ? local_advert_reg    :
    (addr == ADDR_PARTNER_ABIL) ? partner_ability_reg :
    (addr == ADDR_EXPANSION)    ? expansion_reg       :
    (addr == ADDR_IRQ_STATUS)   ? {14'h0000, irq_status} :
    (addr == ADDR_IRQ_MASK)     ? {14'h0000, irq_mask}   :
                                  16'h0000;

  wire [1:0] irq_events = {link.done, link.page_valid};
  // set wins over the read-clear so no event is lost
  wire [1:0] next_irq_status =
    (rd_status ? 2'h0 : irq_status) | irq_events;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      local_advert_reg <= LOCAL_ADVERT_RESET;
    end else if (wr_advert) begin
      local_advert_reg <= next_local_advert;
    end
  end

  // engine only sees the written value after a restart
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      advert <= '{1'b0, TECH_RESET, SEL_IEEE8023};
    end else if (an_restart) begin
      advert <= '{local_advert_reg[REMOTE_FAULT_BIT], tech_field,
                  SEL_IEEE8023};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      partner_ability_reg <= PARTNER_ABIL_RESET;
      partner_sel         <= ANR_SEL_RESERVED;
    end else if (link.page_valid) begin
      partner_ability_reg <= link.page;
      partner_sel         <= next_partner_sel;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      expansion_reg <= EXPANSION_RESET;
    end else if (link.done) begin
      expansion_reg <= next_expansion;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
      irq        <= 1'b0;
      rdata      <= 16'h0000;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= wdata[1:0];
      end
      irq   <= |(next_irq_status & irq_mask);
      rdata <= rd ? next_rdata : 16'h0000;
    end
  end

endmodule : anr_ability_regs

//--- rtl/anr_pkg.sv
package anr_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the management port)
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_LOCAL_ADVERT   = 5'h04;
  localparam logic [4:0]  ADDR_PARTNER_ABIL   = 5'h05;
  localparam logic [4:0]  ADDR_EXPANSION      = 5'h06;
  localparam logic [4:0]  ADDR_IRQ_STATUS     = 5'h1A;
  localparam logic [4:0]  ADDR_IRQ_MASK       = 5'h1B;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int          TECH_LSB            = 5;
  localparam int          TECH_MSB            = 8;
  localparam int          REMOTE_FAULT_BIT    = 13;
  localparam int          NEXT_PAGE_BIT       = 15;
  localparam int          SEL_MSB             = 4;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCAL_ADVERT_RESET  = 16'h01E1;
  localparam logic [15:0] PARTNER_ABIL_RESET  = 16'h0000;
  localparam logic [15:0] EXPANSION_RESET     = 16'h0000;
  localparam logic [15:0] WRITE_MASK_ADVERT   = 16'h21E0;
  localparam logic [3:0]  TECH_RESET          = 4'hF;
  localparam logic [4:0]  SEL_IEEE8023        = 5'h01;
  localparam logic [4:0]  SEL_ISLAN           = 5'h02;
  localparam logic [4:0]  SEL_TOKEN_RING      = 5'h03;
  localparam logic [4:0]  SEL_SERIAL_BUS      = 5'h04;
  localparam logic [1:0]  IRQ_RESET           = 2'h0;
  localparam int          IRQ_PAGE_BIT        = 0;
  localparam int          IRQ_DONE_BIT        = 1;

  // selector decode of the partner page
  typedef enum logic [4:0] {
    ANR_SEL_RESERVED = 5'b00001,
    ANR_SEL_ETHERNET = 5'b00010,
    ANR_SEL_ISLAN    = 5'b00100,
    ANR_SEL_TOKEN    = 5'b01000,
    ANR_SEL_SERIAL   = 5'b10000
  } anr_sel_e;

  // abilities handed to the negotiation engine
  typedef struct packed {
    logic       remote_fault;
    logic [3:0] tech;
    logic [4:0] selector;
  } anr_advert_s;

  // what the engine reports back
  typedef struct packed {
    logic        page_valid;
    logic [15:0] page;
    logic        done;
    logic        partner_an_able;
    logic        partner_np_able;
  } anr_link_s;

endpackage : anr_pkg

//--- test/anr_partner.sv
`timescale 1ns/1ps
module anr_partner import anr_pkg::*; (
  input wire logic clock, go,
  input wire logic [15:0] word,
  output anr_link_s link);
  logic [1:0] st = 2'h0;
  initial link = '0;
  // idle page is inverted so stale data never looks valid
  always @(posedge clock) begin
    link <= {st == 2'h1, st == 2'h1 ? word : ~link.page, st == 2'h2,
      1'b1, word[15]};
    st <= go ? 2'h1 : st + 2'(st != 2'h0);
  end
endmodule : anr_partner

//--- test/anr_properties.sv
`timescale 1ns/1ps
module anr_properties import anr_pkg::*; (
  input wire logic clock, rst, wr, rd, an_restart,
  input wire logic [4:0] addr, input wire logic [15:0] wdata, rdata,
  input wire anr_link_s link, input wire anr_advert_s advert,
  input wire anr_sel_e partner_sel);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [4:0] ps = link.page[4:0];
  wire logic pv = link.page_valid;
  adv_hold_a: assert property (!an_restart |=> $stable(advert))
    else $error("advert moved");
  adv_load_a: assert property (wr && addr == 5'h04 ##1 !wr ##1
    an_restart |=> advert == {$past(wdata[13], 3), $past(wdata[8:5], 3),
    5'h01}) else $error("advert stale");
  sel_read_a: assert property (rd && addr == 5'h04 |=>
    rdata[4:0] == 5'h01 && !rdata[15]) else $error("advert read");
  sel_sent_a: assert property (advert.selector == 5'h01)
    else $error("selector sent");
  adv_reset_a: assert property ($fell(rst) |-> advert == 10'h1E1)
    else $error("advert reset");
  eth_decode_a: assert property (pv && ps == 5'h01 |=>
    partner_sel == ANR_SEL_ETHERNET) else $error("no ethernet");
  res_decode_a: assert property (pv && !(ps inside {[1:4]}) |=>
    partner_sel == ANR_SEL_RESERVED) else $error("no reserved");
  sel_hold_a: assert property (!pv |=> $stable(partner_sel))
    else $error("sel moved");
  cover property (an_restart);
  cover property (link.done);
  cover property (pv && ps == 5'h1F);
endmodule : anr_properties
bind anr_ability_regs anr_properties chk (.*);

//--- test/anr_ability_regs_bench.sv
`timescale 1ns/1ps
module anr_ability_regs_bench;
  import anr_pkg::*;
  logic clock = 0, rst = 1, wr = 0, rd = 0, an_restart = 0, go = 0, irq;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0, word = '0, rdata, exp_adv = 16'h01E1;
  anr_link_s link;
  anr_advert_s advert;
  anr_sel_e partner_sel;
  int error_cnt = 0, tests_run = 0;
  anr_ability_regs DUT (.*);
  anr_partner peer (.*);
  initial forever #5 clock = ~clock;
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [15:0] d);
    @(posedge clock) {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clock) {wr, rd} <= 2'h0;
    #1 if (!w) chk("rdata", d, rdata);
  endtask : bus
  task automatic summarize;
    $display("%0d checks %0d errors", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(52968));
    repeat (20) @(posedge clock);
    rst <= 0;
    for (int a = 4; a < 8; a++)
      bus(0, 5'(a), a == 4 ? 16'h01E1 : 16'h0);
    for (int i = 0; i < 6; i++) begin
      word = i ? 16'($urandom) : 16'hFFFF;
      bus(1, 5'h04, word);
      chk("advert_hold", exp_adv, 16'(advert));
      @(posedge clock) an_restart <= 1;
      @(posedge clock) an_restart <= 0;
      exp_adv = 16'({word[13], word[8:5], 5'h01});
      #1 chk("advert", exp_adv, 16'(advert));
      bus(0, 5'h04, word & 16'h21E0 | 16'h1);
    end
    for (int i = 0; i < 7; i++) begin
      word = 16'($urandom) & 16'hFFE0 | 16'(i == 6 ? 31 : i);
      bus(1, 5'h1B, i ? 16'h3 : 16'h0);
      bus(0, 5'h1B, i ? 16'h3 : 16'h0);
      @(posedge clock) go <= 1;
      @(posedge clock) go <= 0;
      for (int t = 0; !link.done; t++) begin
        if (t > 9) begin error_cnt++; summarize(); end
        @(posedge clock) #1;
      end
      @(posedge clock) #1 chk("irq", 16'(i > 0), 16'(irq));
      bus(0, 5'h05, word);
      chk("sel", 16'(word[4:0] inside {[1:4]} ? 5'h01 << word[4:0]
        : 5'h01), 16'(partner_sel));
      bus(0, 5'h06, {13'h0, word[15], 2'h1});
      bus(0, 5'h1A, 16'h3);
      bus(0, 5'h1A, 16'h0);
    end
    summarize();
  end
endmodule : anr_ability_regs_bench
